// [verification/host_bus_chk_chk.sv]
`timescale 1ns/1ns
module host_bus_chk
(
	input wire       clk_sys_i, sys_rst_i, hw_clear_n_i, chip_sel_n_i, irq_pending_i,
	input wire       addr_bit0_or_mux_select_i, write_strobe_or_direction_i,
	input wire       access_timing_select_i, access_timing_driven_i, wr_pulse_o,
	input wire       rd_pulse_o, irq_out_n_o, core_reset_o, fast_timing_o,
	input wire [7:0] data_in_i, data_driven_i, data_oe_o, wr_data_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i || !hw_clear_n_i);
	wr_one_a: assert property (wr_pulse_o |=> !wr_pulse_o) else $error("wr_one");
	wr_src_a: assert property (wr_pulse_o |-> !$past(chip_sel_n_i) &&
		!$past(write_strobe_or_direction_i)) else $error("wr_src");
	rd_oe_a: assert property (rd_pulse_o |-> data_oe_o == 8'hff) else $error("rd_oe");
	cs_drop_a: assert property (chip_sel_n_i |=> data_oe_o == 8'h00)
		else $error("cs_drop");
	irq_lag_a: assert property (irq_out_n_o != $past(irq_pending_i)) else $error("irq");
	fast_tmg_a: assert property (fast_timing_o ==
		($past(addr_bit0_or_mux_select_i) && $past(access_timing_driven_i) &&
		!$past(access_timing_select_i))) else $error("tmg");
	wr_data_a: assert property (wr_pulse_o |->
		wr_data_o == ($past(data_in_i) | ~$past(data_driven_i))) else $error("wr_data");
	rst_out_a: assert property (disable iff (1'h0) sys_rst_i || !hw_clear_n_i |=>
		core_reset_o && irq_out_n_o) else $error("rst_out");
endmodule // host_bus_chk

bind host_processor_bus_interface host_bus_chk host_bus_chk_i (.*);

// [verification/host_cpu_model.sv]
`timescale 1ns/1ns
module host_cpu_model
(
	input  wire        clk_sys_i,
	input  wire  [7:0] data_out_o,
	output logic       addr_bit0_or_mux_select_i, addr_bit1_i, addr_bit1_driven_i,
	output logic       addr_bit2_or_addr_latch_i, write_strobe_or_direction_i,
	output logic       read_or_data_strobe_i, chip_sel_n_i,
	output logic [7:0] data_in_i, data_driven_i, got_o
);
	initial
	begin
		{addr_bit2_or_addr_latch_i, addr_bit1_i, addr_bit0_or_mux_select_i} = 3'h1;
		{addr_bit1_driven_i, write_strobe_or_direction_i, read_or_data_strobe_i} = 3'h7;
		{chip_sel_n_i, data_in_i, data_driven_i, got_o} = {1'b1, 24'h0};
	end
	task automatic cyc(input bit rd, ds, sel, input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		{addr_bit2_or_addr_latch_i, addr_bit1_i, addr_bit0_or_mux_select_i} = a;
		addr_bit1_driven_i = a[0]; // Left open in muxed mode
		data_in_i = d;
		data_driven_i = rd ? 8'h00 : 8'hff;
		chip_sel_n_i = !sel;
		write_strobe_or_direction_i = rd;
		read_or_data_strobe_i = ds ? 1'h0 : !rd;
		repeat (3) @(negedge clk_sys_i);
		got_o = data_out_o;
		{chip_sel_n_i, write_strobe_or_direction_i, read_or_data_strobe_i} = 3'h7;
		data_driven_i = 8'h00;
		data_in_i = ~d;
		@(negedge clk_sys_i);
	endtask
	task automatic latch(input logic [2:0] a);
		@(negedge clk_sys_i);
		{addr_bit2_or_addr_latch_i, addr_bit1_driven_i, addr_bit0_or_mux_select_i} = 3'h4;
		data_in_i = {5'h00, a};
		data_driven_i = 8'hff;
		@(negedge clk_sys_i);
		addr_bit2_or_addr_latch_i = 1'b0;
	endtask
endmodule // host_cpu_model

// [verification/host_processor_bus_interface_tb.sv]
`timescale 1ns/1ns
module host_processor_bus_interface_tb;
	logic clk_sys_i = 0, sys_rst_i = 1, hw_clear_n_i = 1, host_style_i = 0, irq_pending_i = 0;
	logic access_timing_select_i = 1, access_timing_driven_i = 1;
	logic [7:0] rd_data_i = 8'hc3;
	wire addr_bit0_or_mux_select_i, addr_bit1_i, addr_bit1_driven_i, addr_bit2_or_addr_latch_i;
	wire write_strobe_or_direction_i, read_or_data_strobe_i, chip_sel_n_i;
	wire irq_out_n_o, core_reset_o, wr_pulse_o, rd_pulse_o, muxed_mode_o, fast_timing_o;
	wire [7:0] data_in_i, data_driven_i, data_out_o, data_oe_o, wr_data_o, got_o;
	wire [2:0] reg_addr_o;
	int fail_count = 0, compares = 0, ticks = 0, pulses = 0;
	host_processor_bus_interface host_processor_bus_interface_i (.*);
	host_cpu_model host_cpu_model_i (.*);
	always #2 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		ticks++;
		pulses += wr_pulse_o + rd_pulse_o;
		if (ticks == 3000)
		begin
			fail_count++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic t_sep;
		pulses = 0;
		host_cpu_model_i.cyc(0, 0, 1, 3'h5, 8'h5a);
		chk("wr_data", 8'h5a, wr_data_o);
		chk("reg_addr", 8'h05, {5'h00, reg_addr_o});
		host_cpu_model_i.cyc(1, 0, 1, 3'h7, 8'h00);
		chk("rd_data", 8'hc3, got_o);
		chk("rd_addr", 8'h07, {5'h00, reg_addr_o});
		chk("oe", 8'h00, data_oe_o);
		chk("pulses", 8'h02, pulses[7:0]);
	endtask
	task automatic t_cs;
		pulses = 0;
		host_cpu_model_i.cyc(0, 0, 0, 3'h3, 8'h11);
		host_cpu_model_i.cyc(1, 0, 0, 3'h3, 8'h00);
		chk("pulses", 8'h00, pulses[7:0]);
		chk("wr_data", 8'h5a, wr_data_o);
	endtask
	task automatic t_ds;
		@(negedge clk_sys_i);
		host_style_i = 1;
		rd_data_i = 8'h96;
		host_cpu_model_i.cyc(0, 1, 1, 3'h3, 8'ha5);
		chk("wr_data", 8'ha5, wr_data_o);
		host_cpu_model_i.cyc(1, 1, 1, 3'h1, 8'h00);
		chk("rd_data", 8'h96, got_o);
		host_style_i = 0;
	endtask
	task automatic t_misc;
		irq_pending_i = 1;
		access_timing_select_i = 0;
		repeat (2) @(negedge clk_sys_i);
		chk("irq", 8'h00, {7'h00, irq_out_n_o});
		chk("fast", 8'h01, {7'h00, fast_timing_o});
		irq_pending_i = 0;
		access_timing_driven_i = 0;
		repeat (2) @(negedge clk_sys_i);
		chk("irq", 8'h01, {7'h00, irq_out_n_o});
		chk("fast", 8'h00, {7'h00, fast_timing_o});
		hw_clear_n_i = 0;
		repeat (2) @(negedge clk_sys_i);
		chk("core_reset", 8'h01, {7'h00, core_reset_o});
		hw_clear_n_i = 1;
		repeat (2) @(negedge clk_sys_i);
		chk("core_reset", 8'h00, {7'h00, core_reset_o});
	endtask
	task automatic t_mux;
		access_timing_driven_i = 1;
		host_cpu_model_i.latch(3'h6);
		host_cpu_model_i.cyc(0, 0, 1, 3'h0, 8'h3c);
		chk("reg_addr", 8'h06, {5'h00, reg_addr_o});
		chk("wr_data", 8'h3c, wr_data_o);
		chk("muxed", 8'h01, {7'h00, muxed_mode_o});
		chk("fast_mux", 8'h00, {7'h00, fast_timing_o});
	endtask
	initial
	begin
		repeat (16) @(negedge clk_sys_i);
		sys_rst_i = 0;
		t_sep;
		t_cs;
		t_ds;
		t_misc;
		t_mux;
		print_verdict;
	end
endmodule // host_processor_bus_interface_tb

// [verilog/host_port_defs.vh]
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH

// Register address width and field layout of the shared data lines
`define HP_ADDR_W        3
`define HP_DATA_W        8
`define HP_ADDR_LSB      0
`define HP_ADDR_MSB      2
`define HP_UPPER_LSB     3
`define HP_UPPER_MSB     7

// Reset values
`define HP_ADDR_RST      3'h0
`define HP_DATA_RST      8'h00

// Pull-up level of an undriven line
`define HP_PULL_LEVEL    1'b1
`define HP_PULL_BYTE     8'hff

// Host strobe styles
`define HP_STYLE_SEP     1'b0
`define HP_STYLE_DS      1'b1

// Access timing select levels
`define HP_TMG_FAST      1'b0
`define HP_TMG_NORMAL    1'b1

// Cycle states
`define HP_ST_IDLE       2'h0
`define HP_ST_READ       2'h1
`define HP_ST_WRITE      2'h2

`endif

// [verilog/host_processor_bus_interface.v]
`timescale 1ns/1ns
`include "host_port_defs.vh"

module host_processor_bus_interface
(
	// Clock and reset
	input  wire                    clk_sys_i,
	input  wire                    sys_rst_i,
	// Host address and control pins
	input  wire                    addr_bit0_or_mux_select_i,
	input  wire                    addr_bit1_i,
	input  wire                    addr_bit1_driven_i,
	input  wire                    addr_bit2_or_addr_latch_i,
	input  wire                    write_strobe_or_direction_i,
	input  wire                    read_or_data_strobe_i,
	input  wire                    chip_sel_n_i,
	input  wire                    hw_clear_n_i,
	input  wire                    access_timing_select_i,
	input  wire                    access_timing_driven_i,
	input  wire                    host_style_i,
	// Data pins, four signals each
	input  wire [`HP_DATA_W-1:0]   data_in_i,
	input  wire [`HP_DATA_W-1:0]   data_driven_i,
	output reg  [`HP_DATA_W-1:0]   data_out_o,
	output reg  [`HP_DATA_W-1:0]   data_oe_o,
	// Core side
	input  wire                    irq_pending_i,
	input  wire [`HP_DATA_W-1:0]   rd_data_i,
	output reg                     irq_out_n_o,
	output reg                     core_reset_o,
	output reg                     wr_pulse_o,
	output reg                     rd_pulse_o,
	output reg  [`HP_ADDR_W-1:0]   reg_addr_o,
	output reg  [`HP_DATA_W-1:0]   wr_data_o,
	output reg                     muxed_mode_o,
	output reg                     fast_timing_o
);

	wire [`HP_DATA_W-1:0] data_lvl;
	wire                  a1_lvl;
	wire                  tmg_lvl;

	// Pin levels after the internal pull-ups
	pullup_resolve #(.W(`HP_DATA_W)) u_data_pull
	(
		.line_i        (data_in_i),
		.line_driven_i (data_driven_i),
		.level_o       (data_lvl)
	);

	pullup_resolve #(.W(2)) u_ctl_pull
	(
		.line_i        ({addr_bit1_i, access_timing_select_i}),
		.line_driven_i ({addr_bit1_driven_i, access_timing_driven_i}),
		.level_o       ({a1_lvl, tmg_lvl})
	);

	reg [`HP_ADDR_W-1:0] latch_addr_r;
	reg [1:0]            state_r;
	reg [1:0]            state_nxt;
	reg                  rd_req;
	reg                  wr_req;
	reg                  in_reset;
	reg                  sep_wr;
	reg                  sep_rd;
	reg                  ds_wr;
	reg                  ds_rd;

	wire bus_mux_select_n = addr_bit0_or_mux_select_i;
	wire muxed            = (bus_mux_select_n == 1'b0);
	wire addr_latch       = addr_bit2_or_addr_latch_i;
	wire selected         = ~chip_sel_n_i;
	wire [`HP_ADDR_W-1:0] direct_addr =
		{addr_bit2_or_addr_latch_i, a1_lvl, addr_bit0_or_mux_select_i};
	wire [`HP_ADDR_W-1:0] cur_addr = muxed ? latch_addr_r : direct_addr;
	wire                  idle;
	wire                  start_wr;
	wire                  start_rd;
	wire                  latch_ok;

	assign idle     = (state_r == `HP_ST_IDLE);
	assign start_wr = idle & wr_req;
	assign start_rd = idle & rd_req & ~wr_req;
	// Latch only between cycles, so the address stays put through the strobe
	assign latch_ok = muxed & addr_latch & idle & ~wr_req & ~rd_req;

	// Either reset source holds the block
	always @*
	begin
		in_reset = sys_rst_i | ~hw_clear_n_i;
	end

	// Strobe decode for both host styles
	always @*
	begin
		sep_wr = selected & ~write_strobe_or_direction_i;
		sep_rd = selected & ~read_or_data_strobe_i & write_strobe_or_direction_i;
		ds_wr  = selected & ~read_or_data_strobe_i & ~write_strobe_or_direction_i;
		ds_rd  = selected & ~read_or_data_strobe_i & write_strobe_or_direction_i;
		if (host_style_i == `HP_STYLE_SEP)
		begin
			wr_req = sep_wr;
			rd_req = sep_rd;
		end
		else
		begin
			wr_req = ds_wr;
			rd_req = ds_rd;
		end
	end

	// Access state machine
	always @*
	begin
		case (state_r)
			`HP_ST_IDLE:
			begin
				if (wr_req)
					state_nxt = `HP_ST_WRITE;
				else if (rd_req)
					state_nxt = `HP_ST_READ;
				else
					state_nxt = `HP_ST_IDLE;
			end
			`HP_ST_READ:
				state_nxt = rd_req ? `HP_ST_READ : `HP_ST_IDLE;
			`HP_ST_WRITE:
				state_nxt = wr_req ? `HP_ST_WRITE : `HP_ST_IDLE;
			default:
				state_nxt = `HP_ST_IDLE;
		endcase
	end

	// Status outputs
	always @(posedge clk_sys_i)
	begin
		if (in_reset)
		begin
			core_reset_o  <= 1'b1;
			irq_out_n_o   <= 1'b1;
			muxed_mode_o  <= 1'b0;
			fast_timing_o <= 1'b0;
		end
		else
		begin
			core_reset_o  <= 1'b0;
			irq_out_n_o   <= ~irq_pending_i;
			muxed_mode_o  <= muxed;
			fast_timing_o <= (tmg_lvl == `HP_TMG_FAST) & ~muxed;
		end
	end

	// Access state
	always @(posedge clk_sys_i)
	begin
		if (in_reset)
			state_r <= `HP_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Multiplexed address latch
	always @(posedge clk_sys_i)
	begin
		if (in_reset)
			latch_addr_r <= `HP_ADDR_RST;
		else if (latch_ok)
			latch_addr_r <= data_lvl[`HP_ADDR_MSB:`HP_ADDR_LSB];
	end

	// Access pulses, address and write data
	always @(posedge clk_sys_i)
	begin
		if (in_reset)
		begin
			wr_pulse_o <= 1'b0;
			rd_pulse_o <= 1'b0;
			reg_addr_o <= `HP_ADDR_RST;
			wr_data_o  <= `HP_DATA_RST;
		end
		else
		begin
			wr_pulse_o <= start_wr;
			rd_pulse_o <= start_rd;
			if (start_wr | start_rd)
				reg_addr_o <= cur_addr;
			if (start_wr)
				wr_data_o <= data_lvl;
		end
	end

	// Read data onto the pins while a read stands
	always @(posedge clk_sys_i)
	begin
		if (in_reset)
		begin
			data_out_o <= `HP_DATA_RST;
			data_oe_o  <= `HP_DATA_RST;
		end
		else if (state_nxt == `HP_ST_READ)
		begin
			data_out_o <= rd_data_i;
			data_oe_o  <= `HP_PULL_BYTE;
		end
		else
		begin
			data_out_o <= `HP_DATA_RST;
			data_oe_o  <= `HP_DATA_RST;
		end
	end

endmodule // host_processor_bus_interface

// [verilog/pullup_resolve.v]
`timescale 1ns/1ns
`include "host_port_defs.vh"

// Level seen on a line with an internal pull-up
module pullup_resolve
#(
	parameter W = 1
)
(
	// Line
	input  wire [W-1:0] line_i,
	input  wire [W-1:0] line_driven_i,
	// Resolved
	output wire [W-1:0] level_o
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			assign level_o[i] = line_driven_i[i] ? line_i[i] : `HP_PULL_LEVEL;
		end
	endgenerate

endmodule // pullup_resolve
